// File: scpg_top.sv
// crc-16 engine, byte-parity ram with checker, ram and register write guard
// assumes: sole ahb-lite slave (hready = hreadyout), one clock, sync reset
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "scpg_regs.svh"

module scpg_top
    import scpg_pkg::*;
#(
    parameter int RAM_BYTES = 1536
) (
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire logic           ce,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    input  wire logic           cpu_halt,
    input  wire logic           dma_active,
    output logic                parity_reset_req,
    output scpg_guard_type      sfr_guard,
    output logic                bad_access_detect_enable
);

    localparam int RAM_AW = $clog2(RAM_BYTES);
    localparam logic [7:0] PAR_RST = `SCPG_PAR_RST;

    // ram array: data byte plus its parity bit in bit 8
    logic [8:0]      ram_mem [RAM_BYTES];

    scpg_bus_type    bus_r,        bus_nxt;
    scpg_req_type    req_r,        req_nxt;
    logic            hreadyout_r,  hreadyout_nxt;
    logic [31:0]     hrdata_r,     hrdata_nxt;
    logic            hresp_r;
    logic [7:0]      prot_r,       prot_nxt;
    logic            rst_mask_r,   rst_mask_nxt;
    logic            par_flag_r,   par_flag_nxt;
    logic            ptest_r,      ptest_nxt;
    logic [7:0]      crc_in_r,     crc_in_nxt;
    logic [15:0]     crc_r,        crc_nxt;
    logic            crc_pend_r,   crc_pend_nxt;
    logic            prst_req_r,   prst_req_nxt;

    logic            addr_phase;
    scpg_sel_type    dec_sel;
    logic [19:0]     widx;
    logic [19:0]     ram_off;
    logic            wr_commit;
    logic            rd_done;
    logic [8:0]      ram_rd;
    logic            par_err;
    logic [9:0]      guard_lim;
    logic            ram_blocked;
    logic            ram_we;
    logic [8:0]      ram_wdata;

    // one bit per step, lsb of the byte first
    // register kept reflected, so the result also reads out lsb-first
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] x;
        logic        fb;
        x = c;
        for (int i = 0; i < 8; i++) begin
            fb = x[0] ^ d[i];
            x  = {1'b0, x[15:1]} ^ (fb ? `SCPG_CRC_POLY_REV : 16'h0000);
        end
        return x;
    endfunction

    // address decode
    assign addr_phase = hsel && htrans[1] && hready;
    assign widx       = haddr[21:2];
    assign ram_off    = widx - `SCPG_RAM_BASE_IDX;

    always_comb begin
        dec_sel = SEL_NONE;
        if (haddr[31:22] == 10'h000) begin
            if (widx == `SCPG_PROT_IDX) begin
                dec_sel = SEL_PROT;
            end else if (widx == `SCPG_PAR_IDX) begin
                dec_sel = SEL_PAR;
            end else if (widx == `SCPG_PTEST_IDX) begin
                dec_sel = SEL_PTEST;
            end else if (widx == `SCPG_CRC_INPUT_BYTE_IDX) begin
                dec_sel = SEL_CRC_INPUT_BYTE;
            end else if (widx == `SCPG_CRC_RESULT_IDX) begin
                dec_sel = SEL_CRC_RESULT;
            end else if (widx >= `SCPG_RAM_BASE_IDX &&
                         ram_off < 20'(RAM_BYTES)) begin
                dec_sel = SEL_RAM;
            end
        end
    end

    // ram guard window from the lowest ram byte
    always_comb begin
        unique case (prot_r[`SCPG_PROT_RAMG_LSB +: 2])
            2'b00: guard_lim = 10'h000;
            2'b01: guard_lim = `SCPG_GUARD_SZ1;
            2'b10: guard_lim = `SCPG_GUARD_SZ2;
            2'b11: guard_lim = `SCPG_GUARD_SZ3;
        endcase
    end

    assign wr_commit   = (bus_r == BUS_WR);
    assign rd_done     = (bus_r == BUS_RD2);
    assign ram_rd      = ram_mem[req_r.ram_idx[RAM_AW-1:0]];
    assign ram_blocked = (req_r.ram_idx < 16'(guard_lim));
    assign ram_we      = wr_commit && req_r.sel == SEL_RAM && !ram_blocked;
    // parity test bit stores bad parity so the checker can be exercised
    assign ram_wdata   = {^hwdata[7:0] ^ ptest_r, hwdata[7:0]};
    // always on, no disable exists
    assign par_err     = rd_done && req_r.sel == SEL_RAM &&
                         (^ram_rd != 1'b0);

    always_comb begin
        bus_nxt       = bus_r;
        req_nxt       = req_r;
        hreadyout_nxt = hreadyout_r;
        hrdata_nxt    = hrdata_r;
        prot_nxt      = prot_r;
        rst_mask_nxt  = rst_mask_r;
        par_flag_nxt  = par_flag_r;
        ptest_nxt     = ptest_r;
        crc_in_nxt    = crc_in_r;
        crc_nxt       = crc_r;
        crc_pend_nxt  = 1'b0;
        prst_req_nxt  = 1'b0;

        // data phase writes
        if (wr_commit) begin
            unique case (req_r.sel)
                SEL_PROT: begin
                    prot_nxt = (hwdata[7:0] & `SCPG_PROT_WMASK) |
                               (prot_r & 8'h80) |
                               (hwdata[7:0] & 8'h80);
                end
                SEL_PAR: begin
                    // blocked writes simply vanish
                    if (!prot_r[`SCPG_PROT_CLK_BIT]) begin
                        rst_mask_nxt = hwdata[`SCPG_PAR_MASK_BIT];
                        if (!hwdata[`SCPG_PAR_FLAG_BIT]) begin
                            par_flag_nxt = 1'b0;
                        end
                    end
                end
                SEL_PTEST: ptest_nxt = hwdata[0];
                SEL_CRC_INPUT_BYTE: begin
                    if (req_r.crc_src_ok) begin
                        crc_in_nxt   = hwdata[7:0];
                        crc_pend_nxt = 1'b1;
                    end
                end
                SEL_CRC_RESULT: begin
                    if (!crc_pend_r) begin
                        crc_nxt = hwdata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // result lands one clock after the byte write
        if (crc_pend_r) begin
            crc_nxt = crc_step(crc_r, crc_in_r);
        end

        // set wins over a same-cycle clear
        if (par_err) begin
            par_flag_nxt = 1'b1;
            prst_req_nxt = !rst_mask_r;
        end

        // bus sequencing; reads wait two cycles so a pending crc lands
        unique case (bus_r)
            BUS_RD1: bus_nxt = BUS_RD2;
            BUS_RD2: begin
                bus_nxt       = BUS_IDLE;
                hreadyout_nxt = 1'b1;
                unique case (req_r.sel)
                    SEL_PROT:  hrdata_nxt = {24'h000000, prot_r};
                    SEL_PAR:   hrdata_nxt = {24'h000000, rst_mask_r,
                                             6'h00, par_flag_r};
                    SEL_PTEST: hrdata_nxt = {31'h00000000, ptest_r};
                    SEL_CRC_INPUT_BYTE: hrdata_nxt = {24'h000000, crc_in_r};
                    SEL_CRC_RESULT:  hrdata_nxt = {16'h0000, crc_r};
                    SEL_RAM:   hrdata_nxt = {24'h000000, ram_rd[7:0]};
                    SEL_NONE:  hrdata_nxt = 32'h00000000;
                    default:   hrdata_nxt = 32'h00000000;
                endcase
            end
            BUS_IDLE, BUS_WR: begin
                bus_nxt = BUS_IDLE;
                if (addr_phase) begin
                    req_nxt.sel        = dec_sel;
                    req_nxt.crc_src_ok = dma_active || !cpu_halt;
                    req_nxt.ram_idx    = ram_off[15:0];
                    if (hwrite) begin
                        bus_nxt = BUS_WR;
                    end else begin
                        bus_nxt       = BUS_RD1;
                        hreadyout_nxt = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_r       <= BUS_IDLE;
            req_r       <= '0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h00000000;
            hresp_r     <= 1'b0;
            prot_r      <= `SCPG_PROT_RST;
            rst_mask_r  <= PAR_RST[`SCPG_PAR_MASK_BIT];
            par_flag_r  <= PAR_RST[`SCPG_PAR_FLAG_BIT];
            ptest_r     <= 1'b0;
            crc_in_r    <= `SCPG_CRC_INPUT_BYTE_RST;
            crc_r       <= `SCPG_CRC_RESULT_RST;
            crc_pend_r  <= 1'b0;
            prst_req_r  <= 1'b0;
        end else if (ce) begin
            bus_r       <= bus_nxt;
            req_r       <= req_nxt;
            hreadyout_r <= hreadyout_nxt;
            hrdata_r    <= hrdata_nxt;
            hresp_r     <= 1'b0;
            prot_r      <= prot_nxt;
            rst_mask_r  <= rst_mask_nxt;
            par_flag_r  <= par_flag_nxt;
            ptest_r     <= ptest_nxt;
            crc_in_r    <= crc_in_nxt;
            crc_r       <= crc_nxt;
            crc_pend_r  <= crc_pend_nxt;
            prst_req_r  <= prst_req_nxt;
        end
    end

    // ram has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (ce && ram_we) begin
            ram_mem[req_r.ram_idx[RAM_AW-1:0]] <= ram_wdata;
        end
    end

    assign hrdata                   = hrdata_r;
    assign hreadyout                = hreadyout_r;
    assign hresp                    = hresp_r;
    assign parity_reset_req         = prst_req_r;
    assign sfr_guard.port           = prot_r[`SCPG_PROT_PORT_BIT];
    assign sfr_guard.irq            = prot_r[`SCPG_PROT_IRQ_BIT];
    assign sfr_guard.clk_volt       = prot_r[`SCPG_PROT_CLK_BIT];
    assign bad_access_detect_enable = prot_r[`SCPG_PROT_BAD_BIT];

    default clocking @(posedge clk); endclocking
    default disable iff (srst || !ce);

    sequence s_crc_input_byte_take;
        wr_commit && req_r.sel == SEL_CRC_INPUT_BYTE && req_r.crc_src_ok;
    endsequence

    sequence s_read_addr;
        addr_phase && !hwrite && (bus_r == BUS_IDLE || bus_r == BUS_WR);
    endsequence

    sequence s_read_wait;
        !hreadyout ##1 !hreadyout ##1 hreadyout;
    endsequence

    a_crc_step_store: assert property (
        s_crc_input_byte_take |=> ##1 crc_r == crc_step($past(crc_r),
                                               $past(crc_in_r)))
        else $error("crc result not stored one clock after byte");

    a_crc_back_back: assert property (
        s_crc_input_byte_take ##1 s_crc_input_byte_take |-> crc_pend_r ##1 crc_pend_r)
        else $error("back to back crc byte lost");

    a_crc_seed_drop: assert property (
        wr_commit && req_r.sel == SEL_CRC_RESULT && crc_pend_r
        |=> crc_r == crc_step($past(crc_r), $past(crc_in_r)))
        else $error("seed write overrode computed crc");

    a_crc_seed_take: assert property (
        wr_commit && req_r.sel == SEL_CRC_RESULT && !crc_pend_r
        |=> crc_r == $past(hwdata[15:0]))
        else $error("seed write not stored");

    a_crc_halt_only_dma: assert property (
        wr_commit && req_r.sel == SEL_CRC_INPUT_BYTE && !req_r.crc_src_ok
        |=> !crc_pend_r && $stable(crc_in_r))
        else $error("crc took a non dma byte while halted");

    a_par_flag_set: assert property (
        par_err |=> par_flag_r)
        else $error("parity error did not set flag");

    a_par_reset_req: assert property (
        par_err |=> parity_reset_req == !$past(rst_mask_r))
        else $error("parity reset request wrong");

    a_par_flag_hold: assert property (
        par_flag_r && !(wr_commit && req_r.sel == SEL_PAR)
        |=> par_flag_r)
        else $error("parity flag dropped without a clear");

    a_ram_guard_block: assert property (
        wr_commit && req_r.sel == SEL_RAM &&
        req_r.ram_idx < 16'(guard_lim) |-> !ram_we && !par_err)
        else $error("write reached guarded ram");

    a_sfr_guard_par: assert property (
        wr_commit && req_r.sel == SEL_PAR && prot_r[`SCPG_PROT_CLK_BIT]
        |=> $stable(rst_mask_r) && $stable(par_flag_r))
        else $error("guarded parity control was written");

    a_read_wait: assert property (
        s_read_addr |=> s_read_wait)
        else $error("read answer timing wrong");

    a_crc_input_byte_store: assert property (
        s_crc_input_byte_take |=> crc_in_r == $past(hwdata[7:0]))
        else $error("crc input byte not stored");

    a_crc_store_only: assert property (
        !crc_pend_r && !(wr_commit && req_r.sel == SEL_CRC_RESULT)
        |=> $stable(crc_r))
        else $error("crc result changed without store or seed");

    a_par_ctl_read: assert property (
        rd_done && req_r.sel == SEL_PAR |=> hrdata[6:1] == 6'h00)
        else $error("parity control unused bits not zero");

    a_blocked_quiet: assert property (
        wr_commit && req_r.sel == SEL_RAM && ram_blocked
        |=> !parity_reset_req && $stable(par_flag_r))
        else $error("blocked ram write raised an error");

endmodule

// File: scpg_regs.svh
// register indices, field positions, reset values and counts for scpg_top
// assumes: included by bare name from the top module and the bench
`ifndef SCPG_REGS_SVH
`define SCPG_REGS_SVH

// word indices; byte address is four times the index
`define SCPG_PROT_IDX      20'hF0078
`define SCPG_PAR_IDX       20'hF00F5
`define SCPG_CRC_INPUT_BYTE_IDX     20'hFFFAC
`define SCPG_CRC_RESULT_IDX      20'hFFFAD
`define SCPG_PTEST_IDX     20'hFFFAE
`define SCPG_RAM_BASE_IDX  20'h40000

// protect_control fields
`define SCPG_PROT_BAD_BIT  7
`define SCPG_PROT_RAMG_LSB 4
`define SCPG_PROT_PORT_BIT 2
`define SCPG_PROT_IRQ_BIT  1
`define SCPG_PROT_CLK_BIT  0
`define SCPG_PROT_WMASK    8'h37

// parity_control fields
`define SCPG_PAR_MASK_BIT  7
`define SCPG_PAR_FLAG_BIT  0

// reset values
`define SCPG_PROT_RST      8'h00
`define SCPG_PAR_RST       8'h00
`define SCPG_CRC_INPUT_BYTE_RST     8'h00
`define SCPG_CRC_RESULT_RST      16'h0000

// crc generator: x^16 + x^12 + x^5 + 1
`define SCPG_CRC_POLY      16'h1021
// same generator bit-reversed, for the right-shifting result register
`define SCPG_CRC_POLY_REV  16'h8408

// ram guard sizes in bytes
`define SCPG_GUARD_SZ1     10'h080
`define SCPG_GUARD_SZ2     10'h100
`define SCPG_GUARD_SZ3     10'h200

`endif

// File: scpg_pkg.sv
// types shared by the safety check block
// assumes: scpg_regs.svh is on the include path
package scpg_pkg;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PROT,
        SEL_PAR,
        SEL_PTEST,
        SEL_CRC_INPUT_BYTE,
        SEL_CRC_RESULT,
        SEL_RAM
    } scpg_sel_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WR,
        BUS_RD1,
        BUS_RD2
    } scpg_bus_type;

    // address phase captured for the data phase
    typedef struct packed {
        scpg_sel_type sel;
        logic         crc_src_ok;
        logic [15:0]  ram_idx;
    } scpg_req_type;

    // write-guard enables handed to the guarded register groups
    typedef struct packed {
        logic port;
        logic irq;
        logic clk_volt;
    } scpg_guard_type;

endpackage

// File: scpg_tb.sv
// self-checking bench for scpg_top over its ahb-lite slave port
// assumes: scpg_regs.svh and scpg_pkg on the path, sole slave on the bus
`timescale 1ns/1ps
`include "scpg_regs.svh"

module tb
    import scpg_pkg::*;
;
    localparam logic [31:0] A_PROT  = {10'h000, `SCPG_PROT_IDX, 2'b00};
    localparam logic [31:0] A_PAR   = {10'h000, `SCPG_PAR_IDX, 2'b00};
    localparam logic [31:0] A_CRC_INPUT_BYTE = {10'h000, `SCPG_CRC_INPUT_BYTE_IDX, 2'b00};
    localparam logic [31:0] A_CRC_RESULT  = {10'h000, `SCPG_CRC_RESULT_IDX, 2'b00};
    localparam logic [31:0] A_PTEST = {10'h000, `SCPG_PTEST_IDX, 2'b00};

    logic           clk;
    logic           srst;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic           hwrite;
    logic [31:0]    hwdata;
    logic           hready;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic           cpu_halt;
    logic           dma_active;
    logic           parity_reset_req;
    scpg_guard_type sfr_guard;
    logic           bad_access_detect_enable;
    int             failures;
    int             n_tests;
    int             n_pulse;
    logic [31:0]    pa[4];
    logic [31:0]    pd[4];
    logic [31:0]    rv;
    logic [15:0]    ref_crc;
    int             p0;

    assign hready = hreadyout;

    scpg_top #(.RAM_BYTES(1024)) dut_u (
        .clk                      (clk),
        .srst                     (srst),
        .ce                       (1'b1),
        .hsel                     (1'b1),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (3'b010),
        .hwdata                   (hwdata),
        .hready                   (hready),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .cpu_halt                 (cpu_halt),
        .dma_active               (dma_active),
        .parity_reset_req         (parity_reset_req),
        .sfr_guard                (sfr_guard),
        .bad_access_detect_enable (bad_access_detect_enable)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // reset request pulses are one cycle wide, so count them at every edge
    always @(posedge clk) begin
        if (parity_reset_req === 1'b1) begin
            n_pulse++;
        end
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 40);
        if (hready !== 1'b1) begin
            failures++;
            $display("Error hready expected 1 seen %b", hready);
            end_of_test;
        end
    endtask

    // pipelined writes: address of i overlaps data of i-1
    task automatic wrp(input int n);
        for (int i = 0; i < n; i++) begin
            htrans <= 2'b10;
            haddr  <= pa[i];
            hwrite <= 1'b1;
            if (i > 0) begin
                hwdata <= pd[i-1];
            end
            wait_rdy;
        end
        htrans <= 2'b00;
        hwdata <= pd[n-1];
        wait_rdy;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        pa[0] = a;
        pd[0] = d;
        wrp(1);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= 1'b0;
        wait_rdy;
        htrans <= 2'b00;
        wait_rdy;
        d = hrdata;
    endtask

    task automatic rdc(input string name, input logic [31:0] a,
                       input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, d, exp);
    endtask

    function automatic logic [31:0] ram_a(input int n);
        return 32'h0010_0000 + (32'(n) << 2);
    endfunction

    // bench model: bit 0 of the byte enters first, register reflected
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic fb;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ b[i];
            c  = {1'b0, c[15:1]} ^ (fb ? `SCPG_CRC_POLY_REV : 16'h0000);
        end
        return c;
    endfunction

    initial begin
        failures = 0;
        n_tests = 0;
        n_pulse = 0;
        srst = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        cpu_halt = 1'b0;
        dma_active = 1'b0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);

        rdc("prot", A_PROT, 32'h0000_0000);
        rdc("par", A_PAR, 32'h0000_0000);
        rdc("crc_input_byte", A_CRC_INPUT_BYTE, 32'h0000_0000);
        rdc("crc_result", A_CRC_RESULT, 32'h0000_0000);
        rdc("unmapped", 32'h0000_0000, 32'h0000_0000);
        $display("test reset_values done");

        // four bytes back to back, no gap between them
        pa = '{A_CRC_INPUT_BYTE, A_CRC_INPUT_BYTE, A_CRC_INPUT_BYTE, A_CRC_INPUT_BYTE};
        pd = '{32'h78, 32'h56, 32'h34, 32'h12};
        wrp(4);
        ref_crc = 16'h0000;
        foreach (pd[i]) ref_crc = crc_step(ref_crc, pd[i][7:0]);
        rdc("crc_result_ex", A_CRC_RESULT, 32'h0000_08F6);
        rdc("crc_result_ref", A_CRC_RESULT, {16'h0000, ref_crc});
        wr(A_CRC_RESULT, 32'h0000_FFFF);
        // seed read back before the next byte goes in
        rdc("seed", A_CRC_RESULT, 32'h0000_FFFF);
        // seed write comes on the edge that stores the crc of the byte before it, so it is dropped
        pa[0] = A_CRC_INPUT_BYTE;
        pd[0] = 32'hA5;
        pa[1] = A_CRC_RESULT;
        pd[1] = 32'h1234;
        wrp(2);
        ref_crc = crc_step(16'hFFFF, 8'hA5);
        rdc("collide", A_CRC_RESULT, {16'h0000, ref_crc});
        rdc("crc_input_byte_rb", A_CRC_INPUT_BYTE, 32'h0000_00A5);
        $display("test crc done");

        cpu_halt <= 1'b1;
        wr(A_CRC_INPUT_BYTE, 32'h55);
        rdc("halt_cpu", A_CRC_RESULT, {16'h0000, ref_crc});
        dma_active <= 1'b1;
        wr(A_CRC_INPUT_BYTE, 32'h55);
        ref_crc = crc_step(ref_crc, 8'h55);
        rdc("halt_dma", A_CRC_RESULT, {16'h0000, ref_crc});
        cpu_halt <= 1'b0;
        dma_active <= 1'b0;
        $display("test halt done");

        for (int i = 0; i < 3; i++) begin
            wr(A_PROT, 32'(1 << i));
            @(posedge clk);
            #1;
            chk("sfr_guard", {29'h0, sfr_guard}, 32'(1 << i));
        end
        // only the clock/volt/parity group covers parity control
        wr(A_PROT, 32'h01);
        wr(A_PAR, 32'h80);
        rdc("par_guarded", A_PAR, 32'h0000_0000);
        wr(A_PROT, 32'h80);
        wr(A_PROT, 32'h00);
        rdc("bad_sticky", A_PROT, 32'h0000_0080);
        chk("bad_out", {31'h0, bad_access_detect_enable}, 32'h1);
        wr(32'h0000_0000, 32'hFF);
        rdc("unmapped_wr", 32'h0000_0000, 32'h0000_0000);
        $display("test sfr_guard done");

        foreach (pa[i]) begin
            wr(ram_a(128 << i), 32'h11);
            wr(ram_a((128 << i) - 1), 32'h11);
        end
        p0 = n_pulse;
        for (int c = 1; c < 4; c++) begin
            wr(A_PROT, 32'(c << 4));
            wr(ram_a((64 << c) - 1), 32'hA0 + 32'(c));
            wr(ram_a(64 << c), 32'hB0 + 32'(c));
            rdc("ram_in", ram_a((64 << c) - 1), 32'h11);
            rdc("ram_out", ram_a(64 << c), 32'hB0 + 32'(c));
        end
        wr(A_PROT, 32'h00);
        rdc("no_flag", A_PAR, 32'h0000_0000);
        chk("no_pulse", 32'(n_pulse), 32'(p0));
        $display("test ram_guard done");

        wr(A_PTEST, 32'h1);
        wr(ram_a(300), 32'h3C);
        wr(A_PTEST, 32'h0);
        rd(ram_a(300), rv);
        chk("ram_bad", rv, 32'h0000_003C);
        rdc("flag_set", A_PAR, 32'h0000_0001);
        chk("rst_req", 32'(n_pulse), 32'(p0 + 1));
        wr(A_PAR, 32'h01);
        rdc("flag_w1", A_PAR, 32'h0000_0001);
        wr(ram_a(301), 32'h5A);
        rdc("ram_good", ram_a(301), 32'h0000_005A);
        rdc("flag_keep", A_PAR, 32'h0000_0001);
        wr(A_PAR, 32'h00);
        rdc("flag_clr", A_PAR, 32'h0000_0000);
        wr(A_PAR, 32'h80);
        rd(ram_a(300), rv);
        rdc("flag_mask", A_PAR, 32'h0000_0081);
        chk("no_rst", 32'(n_pulse), 32'(p0 + 1));
        $display("test parity done");

        // a reset in mid-run must clear the sticky flag and the result
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rdc("flag_rst", A_PAR, 32'h0000_0000);
        rdc("crc_result_rst", A_CRC_RESULT, 32'h0000_0000);
        $display("test mid_reset done");
        end_of_test;
    end
endmodule
